// ==== rtl/slb_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low synchronised reset.
`timescale 1ns/1ns
module slb_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [AW:0]   cnt_r;
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  // ==========================================================
  // Handshake decode.
  wire wr_go = in_valid & in_ready;
  wire rd_go = out_valid & out_ready;
  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  // Pointers and fill count move on accepted handshakes.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      wp_r  <= '0;
      rp_r  <= '0;
    end else begin
      if (wr_go) wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      if (rd_go) rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(wr_go) - (AW+1)'(rd_go);
    end
  end
  // Storage array, written without reset.
  always_ff @(posedge clk) begin
    if (wr_go) mem_r[wp_r] <= in_data;
  end
endmodule

// ==== rtl/slb_pkg.sv ====
// Package for the serial line buffer controller: constants and codes.
// Assumes a 20 MHz system clock and no register bus.
package slb_pkg;
  // ==========================================================
  // Clock and baud rates
  localparam int unsigned SLB_CLK_HZ    = 20000000;
  localparam int unsigned SLB_OVERSMP   = 16;
  localparam logic [4:0]  SLB_SEL_9600  = 5'h00;
  localparam logic [4:0]  SLB_SEL_4800  = 5'h04;
  localparam logic [4:0]  SLB_SEL_2400  = 5'h08;
  localparam logic [4:0]  SLB_SEL_1200  = 5'h0c;
  localparam logic [4:0]  SLB_SEL_600   = 5'h10;
  localparam logic [4:0]  SLB_SEL_300   = 5'h14;
  localparam logic [4:0]  SLB_SEL_150   = 5'h18;
  localparam logic [4:0]  SLB_SEL_200   = 5'h1a;
  localparam logic [4:0]  SLB_SEL_110   = 5'h1f;
  // Divider reload: cycles of clk per 16x tick, minus one.
  function automatic logic [15:0] slb_div(input int unsigned baud);
    slb_div = 16'((SLB_CLK_HZ / (baud * SLB_OVERSMP)) - 1);
  endfunction
  // ==========================================================
  // Control characters
  localparam logic [7:0] SLB_CH_LF  = 8'h0a;
  localparam logic [7:0] SLB_CH_VT  = 8'h0b;
  localparam logic [7:0] SLB_CH_FF  = 8'h0c;
  localparam logic [7:0] SLB_CH_CR  = 8'h0d;
  localparam logic [7:0] SLB_CH_DC3 = 8'h13;
  localparam logic [7:0] SLB_CH_DEL = 8'h7f;
  localparam logic [7:0] SLB_CH_SP  = 8'h20;
  localparam logic [7:0] SLB_LINE_MAX = 8'd132;
  // ==========================================================
  // Firmware patch window
  localparam logic [15:0] SLB_PATCH_LO = 16'h0038;
  localparam logic [15:0] SLB_PATCH_HI = 16'h003f;
  // ==========================================================
  // Receiver states
  typedef enum logic [3:0] {
    SLB_RX_IDLE  = 4'b0001,
    SLB_RX_START = 4'b0010,
    SLB_RX_DATA  = 4'b0100,
    SLB_RX_STOP  = 4'b1000
  } slb_rx_e;
endpackage

// ==== rtl/slb_top.sv ====
// Line buffer controller: receiver, parallel port, FIFO, busy and ack.
// Assumes pins arrive asynchronous to clk; processor side is on clk.
`timescale 1ns/1ns
module slb_top
  import slb_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter bit ALT_RATES  = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       serial_rx,
  input  wire logic       data_set_ready,
  input  wire logic       carrier_present,
  input  wire logic       parity_en,
  input  wire logic       parity_odd,
  input  wire logic [4:0] baud_sel,
  input  wire logic [7:0] par_data,
  input  wire logic       par_strobe_n,
  input  wire logic       online,
  input  wire logic       cpu_busy,
  input  wire logic       line_busy_clear,
  input  wire logic [15:0] cpu_addr,
  input  wire logic       cpu_rd_ready,
  output logic [7:0]      cpu_rd_data,
  output logic            cpu_rd_valid,
  output logic            data_terminal_ready,
  output logic            reverse_channel_status,
  output logic            host_busy,
  output logic            ack_pulse,
  output logic            test_mode,
  output logic            patch_prom_sel,
  output logic            ctrl_char_seen,
  output logic            del_seen,
  output logic            rx_error
);
  // ==========================================================
  // Reset release and input synchronisers
  logic [1:0] rst_sync_r;
  wire        rst_s_n = rst_sync_r[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_sync_r <= 2'b00;
    else        rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  // Three-stage chains; a level counts once stages two and three agree.
  logic [2:0] rx_s_r, dsr_s_r, cd_s_r, stb_s_r;
  logic       rx_q_r, dsr_q_r, cd_q_r, stb_q_r;
  logic [7:0] pd_s1_r, pd_s2_r;
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rx_s_r  <= 3'h7;
      dsr_s_r <= 3'h0;
      cd_s_r  <= 3'h0;
      stb_s_r <= 3'h7;
      {rx_q_r, dsr_q_r, cd_q_r, stb_q_r} <= 4'b1001;
    end else begin
      rx_s_r  <= {rx_s_r[1:0], serial_rx};
      dsr_s_r <= {dsr_s_r[1:0], data_set_ready};
      cd_s_r  <= {cd_s_r[1:0], carrier_present};
      stb_s_r <= {stb_s_r[1:0], par_strobe_n};
      if (rx_s_r[1] == rx_s_r[2])   rx_q_r  <= rx_s_r[2];
      if (dsr_s_r[1] == dsr_s_r[2]) dsr_q_r <= dsr_s_r[2];
      if (cd_s_r[1] == cd_s_r[2])   cd_q_r  <= cd_s_r[2];
      if (stb_s_r[1] == stb_s_r[2]) stb_q_r <= stb_s_r[2];
    end
  end
  // Parallel data is stable around the strobe; two stages suffice.
  always_ff @(posedge clk) begin
    pd_s1_r <= par_data;
    pd_s2_r <= pd_s1_r;
  end

  // Line idles at mark unless both qualifiers are asserted.
  wire rx_line = rx_q_r | ~(dsr_q_r & cd_q_r);

  // ==========================================================
  // Baud divider: one-cycle 16x tick enable
  logic [15:0] div_load;
  always_comb begin
    div_load = slb_div(9600);
    unique case (baud_sel)
      SLB_SEL_9600: div_load = slb_div(9600);
      SLB_SEL_4800: div_load = ALT_RATES ? slb_div(9600) : slb_div(4800);
      SLB_SEL_2400: div_load = slb_div(2400);
      SLB_SEL_1200: div_load = slb_div(1200);
      SLB_SEL_600:  div_load = slb_div(600);
      SLB_SEL_300:  div_load = slb_div(300);
      SLB_SEL_150:  div_load = ALT_RATES ? slb_div(200) : slb_div(150);
      SLB_SEL_200:  div_load = slb_div(200);
      SLB_SEL_110:  div_load = slb_div(110);
      default:      div_load = slb_div(9600);
    endcase
  end
  logic [15:0] div_r;
  wire         tick16 = (div_r == 16'h0000);
  // Reload on terminal count gives sixteen ticks per bit.
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n)    div_r <= 16'h0000;
    else if (tick16) div_r <= div_load;
    else             div_r <= div_r - 16'h0001;
  end

  // ==========================================================
  // Receiver: samples each bit at tick 8 of 16
  slb_rx_e     rx_st_r;
  logic [3:0]  ph_r;
  logic [3:0]  bit_r;
  logic [8:0]  sh_r;
  logic        char_received_flag;
  logic [7:0]  rx_byte_r;
  wire         mid = tick16 && (ph_r == 4'h7);
  wire [3:0]   nbits = parity_en ? 4'h9 : 4'h8;
  wire         par_bad = parity_en &&
                         ((^sh_r) != parity_odd);
  wire         stop_mid = (rx_st_r == SLB_RX_STOP) && mid;
  logic        char_received_clear;
  // Start, data LSB first, optional parity, then stop.
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rx_st_r <= SLB_RX_IDLE;
      ph_r <= 4'h0;
      bit_r <= 4'h0;
      sh_r <= 9'h000;
      rx_byte_r <= 8'h00;
      rx_error <= 1'b0;
    end else begin
      if (tick16) ph_r <= ph_r + 4'h1;
      unique case (rx_st_r)
        SLB_RX_IDLE: if (!rx_line) begin
          rx_st_r <= SLB_RX_START;
          ph_r <= 4'h0;
        end
        SLB_RX_START: if (mid) begin
          rx_st_r <= rx_line ? SLB_RX_IDLE : SLB_RX_DATA;
          bit_r <= 4'h0;
        end
        SLB_RX_DATA: if (mid) begin
          sh_r <= parity_en ? {rx_line, sh_r[8:1]}
                            : {1'b0, rx_line, sh_r[7:1]};
          bit_r <= bit_r + 4'h1;
          if (bit_r == nbits - 4'h1) rx_st_r <= SLB_RX_STOP;
        end
        SLB_RX_STOP: if (mid) begin
          rx_st_r <= SLB_RX_IDLE;
          rx_byte_r <= sh_r[7:0];
          rx_error <= ~rx_line | par_bad;
        end
      endcase
    end
  end
  // Flag rises when the stop bit is sampled; set wins over clear.
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n)                 char_received_flag <= 1'b0;
    else if (stop_mid)            char_received_flag <= 1'b1;
    else if (char_received_clear) char_received_flag <= 1'b0;
  end

  // ==========================================================
  // Parallel port: byte is taken on the strobe's trailing edge
  wire par_take = ~stb_q_r & stb_s_r[2] & (stb_s_r[1] == stb_s_r[2]);

  // ==========================================================
  // Store strobe, decoder and printable counter
  logic       ack_req_r;
  logic       stored_r;
  logic       fifo_ready;
  wire        fifo_store_strobe = char_received_flag & ~stored_r & fifo_ready;
  wire        par_store = par_take & fifo_ready;
  wire [7:0]  in_byte = par_take ? pd_s2_r : rx_byte_r;
  wire        any_store = fifo_store_strobe | par_store;
  wire        is_term = (in_byte == SLB_CH_CR) | (in_byte == SLB_CH_LF) |
                        (in_byte == SLB_CH_VT) | (in_byte == SLB_CH_FF);
  wire        is_ctrl = is_term | (in_byte == SLB_CH_DC3) |
                        (in_byte == SLB_CH_DEL);
  wire        is_print = (in_byte >= SLB_CH_SP) && (in_byte != SLB_CH_DEL);
  logic [7:0] pcount_r;
  wire        carry = any_store && is_print &&
                      (pcount_r == SLB_LINE_MAX - 8'd1);
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pcount_r <= 8'h00;
    end else if (any_store) begin
      if (is_term || carry) pcount_r <= 8'h00;
      else if (is_print)    pcount_r <= pcount_r + 8'h01;
    end
  end
  // Decoder outputs are registered one-cycle pulses.
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ctrl_char_seen <= 1'b0;
      del_seen       <= 1'b0;
    end else begin
      ctrl_char_seen <= any_store & is_ctrl;
      del_seen       <= any_store & (in_byte == SLB_CH_DEL);
    end
  end

  // ==========================================================
  // Line busy latch and host busy
  logic line_busy_latch;
  wire  busy_set = any_store & (is_ctrl | carry);
  // Set wins over the firmware clear on empty buffer.
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n)             line_busy_latch <= 1'b0;
    else if (busy_set)        line_busy_latch <= 1'b1;
    else if (line_busy_clear) line_busy_latch <= 1'b0;
  end
  // Store happens the cycle after stop midpoint or at strobe trailing edge.
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      host_busy              <= 1'b0;
      reverse_channel_status <= 1'b0;
      data_terminal_ready    <= 1'b0;
    end else begin
      host_busy              <= line_busy_latch | busy_set | cpu_busy;
      reverse_channel_status <= line_busy_latch | busy_set | cpu_busy;
      data_terminal_ready    <= online;
    end
  end

  // ==========================================================
  // Acknowledge request: set by event, advanced by the store
  // The flag clear stands on the ack edge itself, so a held flag cannot
  // strobe the same byte into the FIFO a second time.
  assign char_received_clear = ack_req_r & stored_r;
  // Request sets on an event and clears when the ack is issued.
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      ack_req_r <= 1'b0;
      stored_r  <= 1'b0;
      ack_pulse <= 1'b0;
    end else begin
      ack_pulse <= ack_req_r & stored_r;
      if (ack_req_r & stored_r) begin
        ack_req_r <= 1'b0;
        stored_r  <= 1'b0;
      end else begin
        if (stop_mid | par_take) ack_req_r <= 1'b1;
        if (any_store)           stored_r  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Line FIFO toward the processor
  logic [7:0] fifo_q;
  logic       fifo_v;
  slb_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_s_n),
    .in_data   (in_byte),
    .in_valid  (any_store),
    .in_ready  (fifo_ready),
    .out_data  (fifo_q),
    .out_valid (fifo_v),
    .out_ready (cpu_rd_ready & ~cpu_rd_valid)
  );
  // Output stage registers one word at a time.
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      cpu_rd_valid <= 1'b0;
      cpu_rd_data  <= 8'h00;
    end else if (cpu_rd_valid) begin
      cpu_rd_valid <= 1'b0;
    end else if (fifo_v & cpu_rd_ready) begin
      cpu_rd_valid <= 1'b1;
      cpu_rd_data  <= fifo_q;
    end
  end

  // ==========================================================
  // Patch window decode
  wire in_patch = (cpu_addr >= SLB_PATCH_LO) && (cpu_addr <= SLB_PATCH_HI);
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      test_mode      <= 1'b0;
      patch_prom_sel <= 1'b0;
    end else begin
      test_mode      <= in_patch;
      patch_prom_sel <= in_patch;
    end
  end

  // ==========================================================
  // Checks
  busy_serial_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    ($past(stop_mid) && fifo_store_strobe && busy_set) |=> host_busy)
    else $error("serial busy late");
  busy_or_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    $past(cpu_busy) |-> host_busy) else $error("cpu busy not passed");
  ack_after_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    $rose(ack_pulse) |-> $past(any_store, 2)) else $error("ack before store");
  ack_one_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    ack_pulse |=> !ack_pulse) else $error("ack too long");
  flag_set_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    stop_mid |=> char_received_flag) else $error("flag not set");
  busy_set_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    busy_set |=> line_busy_latch) else $error("busy latch missed");
  count_clr_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    (any_store && is_term) |=> pcount_r == 8'h00) else $error("count kept");
  patch_sel_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    (cpu_addr == 16'h003a) |=> test_mode) else $error("patch decode");
  dtr_a: assert property (@(posedge clk) disable iff (!rst_s_n)
    online |=> data_terminal_ready) else $error("dtr wrong");
endmodule

// ==== verif/serial_line_buffer_control_bench.sv ====
// Self-checking bench for the line buffer controller.
// Assumes slb_top, slb_pkg and the host model; the bench drains the FIFO.
`timescale 1ns/1ns
module serial_line_buffer_control_bench;
  import slb_pkg::*;
  localparam int BIT = (SLB_CLK_HZ / (9600 * SLB_OVERSMP)) * SLB_OVERSMP;
  logic        clk, rst_n, data_set_ready, carrier_present, parity_en;
  logic        parity_odd, online, cpu_busy, line_busy_clear, cpu_rd_ready;
  logic [4:0]  baud_sel;
  logic [15:0] cpu_addr, a;
  logic [7:0]  par_data, cpu_rd_data, b;
  logic        serial_rx, par_strobe_n, cpu_rd_valid, data_terminal_ready;
  logic        reverse_channel_status, host_busy, ack_pulse, test_mode;
  logic        patch_prom_sel, ctrl_char_seen, del_seen, rx_error;
  int          n_errors, samples_checked, ack_cnt, ctrl_cnt, del_cnt;
  int          a0, c0, d0;
  time         t_busy, t_strb, t_start, d;
  logic [7:0]  sent [$];
  logic [7:0]  ctl [6] = '{SLB_CH_DEL, SLB_CH_DC3, SLB_CH_VT, SLB_CH_FF,
                          SLB_CH_LF, SLB_CH_CR};

  slb_host_model host (.clk(clk), .serial_rx(serial_rx),
    .par_data(par_data), .par_strobe_n(par_strobe_n));

  slb_top #(.FIFO_DEPTH(8), .ALT_RATES(1'b0)) uut (
    .clk(clk), .rst_n(rst_n), .serial_rx(serial_rx),
    .data_set_ready(data_set_ready), .carrier_present(carrier_present),
    .parity_en(parity_en), .parity_odd(parity_odd), .baud_sel(baud_sel),
    .par_data(par_data), .par_strobe_n(par_strobe_n), .online(online),
    .cpu_busy(cpu_busy), .line_busy_clear(line_busy_clear),
    .cpu_addr(cpu_addr), .cpu_rd_ready(cpu_rd_ready),
    .cpu_rd_data(cpu_rd_data), .cpu_rd_valid(cpu_rd_valid),
    .data_terminal_ready(data_terminal_ready),
    .reverse_channel_status(reverse_channel_status),
    .host_busy(host_busy), .ack_pulse(ack_pulse), .test_mode(test_mode),
    .patch_prom_sel(patch_prom_sel), .ctrl_char_seen(ctrl_char_seen),
    .del_seen(del_seen), .rx_error(rx_error));

  // ==========================================================
  // Clock and event recorders for pulse counts and edge times.
  initial clk = 1'b0;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (ack_pulse === 1'b1) ack_cnt++;
    if (ctrl_char_seen === 1'b1) ctrl_cnt++;
    if (del_seen === 1'b1) del_cnt++;
  end
  always @(posedge host_busy) t_busy = $time;
  always @(posedge par_strobe_n) t_strb = $time;
  always @(negedge serial_rx) if (t_start === 0) t_start = $time;

  // Expected patch window selection for an address.
  function automatic logic in_patch(input logic [15:0] x);
    return x >= SLB_PATCH_LO && x <= SLB_PATCH_HI;
  endfunction

  // Random printable byte, space excluded.
  function automatic logic [7:0] rnd_print();
    return 8'h21 + 8'($urandom() % 94);
  endfunction

  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Reads one word; present says whether a word must come out.
  task automatic read_byte(input logic [7:0] exp, input logic present);
    logic       got;
    logic [7:0] v;
    got = 1'b0;
    v = 8'h00;
    @(posedge clk) cpu_rd_ready <= 1'b1;
    @(posedge clk) cpu_rd_ready <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (!got && cpu_rd_valid === 1'b1) begin
        got = 1'b1;
        v = cpu_rd_data;
      end
      @(posedge clk);
    end
    #1;
    check(got, present);
    if (present) check(v, exp);
  endtask

  // Sends one parallel byte, drains it and counts its acknowledge.
  task automatic send_rd(input logic [7:0] x);
    a0 = ack_cnt;
    host.send_par(x);
    read_byte(x, 1'b1);
    check(ack_cnt - a0, 1);
  endtask

  // Firmware-style clear of the line busy latch.
  task automatic clear_busy;
    @(posedge clk) line_busy_clear <= 1'b1;
    @(posedge clk) line_busy_clear <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog: the sequence needs about 70000 cycles.
  initial begin
    #(100000 * 50);
    n_errors++;
    report_and_stop();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    data_set_ready = 1'b0;
    carrier_present = 1'b0;
    parity_en = 1'b0;
    parity_odd = 1'b0;
    baud_sel = SLB_SEL_9600;
    online = 1'b0;
    cpu_busy = 1'b0;
    line_busy_clear = 1'b0;
    cpu_rd_ready = 1'b0;
    cpu_addr = 16'h0000;
    void'($urandom(17));
    repeat (3) @(posedge clk);
    #1 check({host_busy, ack_pulse}, 0);
    check({data_terminal_ready, cpu_rd_valid}, 0);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    online <= 1'b1;
    cpu_busy <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check(data_terminal_ready, 1'b1);
    check({host_busy, reverse_channel_status}, 2'b11);
    @(posedge clk) cpu_busy <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(host_busy, 1'b0);
    for (int i = 0; i < 32; i++) begin
      a = (i < 24) ? 16'h0030 + 16'(i) : 16'($urandom());
      @(posedge clk) cpu_addr <= a;
      repeat (2) @(posedge clk);
      #1 check({test_mode, patch_prom_sel}, {2{in_patch(a)}});
    end
    // Fill the FIFO past its depth with the reader stalled, then drain.
    for (int i = 0; i < 9; i++) begin
      b = rnd_print();
      host.send_par(b);
      if (i < 8) sent.push_back(b);
    end
    foreach (sent[i]) read_byte(sent[i], 1'b1);
    read_byte(8'h00, 1'b0);
    foreach (ctl[i]) begin
      clear_busy();
      check(host_busy, 1'b0);
      c0 = ctrl_cnt;
      d0 = del_cnt;
      send_rd(ctl[i]);
      check(ctrl_cnt - c0, 1);
      check(del_cnt - d0, ctl[i] == SLB_CH_DEL);
      check(host_busy, 1'b1);
      check(t_busy > t_strb && t_busy - t_strb <= 400, 1'b1);
    end
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk);
    #1 check({host_busy, ack_pulse}, 2'b00);
    @(posedge clk) rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    send_rd(SLB_CH_CR);
    clear_busy();
    repeat (131) send_rd(rnd_print());
    check(host_busy, 1'b0);
    send_rd(rnd_print());
    check(host_busy, 1'b1);
    send_rd(SLB_CH_CR);
    clear_busy();
    repeat (5) send_rd(rnd_print());
    send_rd(SLB_CH_LF);
    clear_busy();
    repeat (131) send_rd(rnd_print());
    check(host_busy, 1'b0);
    // Serial traffic at 9600 with both qualifiers raised and carrier dropped.
    @(posedge clk) data_set_ready <= 1'b1;
    carrier_present <= 1'b1;
    parity_en <= 1'b1;
    parity_odd <= 1'b1;
    a0 = ack_cnt;
    b = rnd_print();
    host.send_serial(b, BIT, int'(~^b));
    read_byte(b, 1'b1);
    check(ack_cnt - a0, 1);
    check(rx_error, 1'b0);
    @(posedge clk) carrier_present <= 1'b0;
    parity_en <= 1'b0;
    host.send_serial(rnd_print(), BIT);
    read_byte(8'h00, 1'b0);
    @(posedge clk) carrier_present <= 1'b1;
    clear_busy();
    t_start = 0;
    host.send_serial(SLB_CH_CR, BIT);
    d = (t_busy - t_start) / 50;
    check(d >= 9 * BIT + BIT / 2 - BIT / 16, 1'b1);
    check(d <= 9 * BIT + BIT / 2 + BIT / 16 + 12, 1'b1);
    check(reverse_channel_status, 1'b1);
    read_byte(SLB_CH_CR, 1'b1);
    report_and_stop();
  end
endmodule

// ==== verif/slb_host_model.sv ====
// Sending host model: drives the serial line and the parallel port.
// Assumes the bench supplies clk and calls the tasks by hierarchy.
`timescale 1ns/1ns
module slb_host_model (
  input  wire logic       clk,
  output logic            serial_rx,
  output logic [7:0]      par_data,
  output logic            par_strobe_n
);
  // ==========================================================
  // Idle levels: the line rests at mark and the strobe is inactive.
  initial begin
    serial_rx = 1'b1;
    par_data = 8'h5a;
    par_strobe_n = 1'b1;
  end

  // Sends start, eight data bits least significant first, a parity bit
  // when par is 0 or 1, and one stop bit.
  task automatic send_serial(input logic [7:0] b, input int bit_clks,
                             input int par = 2);
    logic [10:0] fr;
    int          n;
    fr = (par < 2) ? {1'b1, par[0], b, 1'b0} : {2'b11, b, 1'b0};
    n = (par < 2) ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge clk) serial_rx <= fr[i];
      repeat (bit_clks - 1) @(posedge clk);
    end
    @(posedge clk);
  endtask

  // Strobes one byte; the data is held well past the trailing edge.
  task automatic send_par(input logic [7:0] b);
    @(posedge clk) par_data <= b;
    par_strobe_n <= 1'b0;
    repeat (4) @(posedge clk);
    par_strobe_n <= 1'b1;
    repeat (6) @(posedge clk);
    par_data <= ~b; // Released bus no longer shows the byte.
    repeat (2) @(posedge clk);
  endtask
endmodule
